//--- logic/pld_block_pkg.sv
// Constants shared by the programmable logic input gating block
package pld_block_pkg;
    localparam int          CLK_PERIOD_NS  = 20;
    // Shortest quiet time before the logic arrays latch and sleep
    localparam int          PLD_LATCH_NS   = 100;
    localparam int          PLD_LATCH_CYC  = (PLD_LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          LATCH_W        = 4;
    localparam logic [3:0]  IDLE_LIMIT     = 4'hF;

    // Register select codes on the register port
    localparam logic        SEL_POWER_CTRL = 1'h0;
    localparam logic        SEL_INPUT_BLK  = 1'h1;
    localparam logic [7:0]  REG_RESET      = 8'h00;

    // Power control fields
    localparam int          PC_AUTO_PD_EN  = 1;
    localparam int          PC_TURBO_OFF   = 3;
    localparam int          PC_CLK_BUS_BLK = 4;
    localparam int          PC_CLK_MC_BLK  = 5;

    // Input block fields: strobe i sits at IB_STROBE_LSB + i
    localparam int          IB_STROBE_LSB  = 2;
    localparam int          IB_PORTC7      = 6;

    // Synchroniser lanes
    localparam int          LN_RD          = 0;
    localparam int          LN_WR          = 1;
    localparam int          LN_PSEN        = 2;
    localparam int          LN_ALE         = 3;
    localparam int          LN_PORTC7      = 4;
    localparam int          LN_CLK         = 5;
    localparam int          LN_BAT         = 6;
    localparam int          N_LANES        = 7;

    // Level shown on the logic input bus by a blocked input
    localparam logic [4:0]  BUS_IDLE       = 5'h07;
    localparam logic [6:0]  PIN_RESET      = 7'h07;
endpackage

//--- logic/pld_input_blocking.sv
// Input gating, clock distribution and auto power-down for the programmable logic arrays
// Contract
// - Input-block bits 2..5 each block one bus strobe from the logic input bus.
// - Blocking touches only the logic bus; strobes always reach the memory arrays.
// - Input-block bit 6 blocks the port C bit 7 input from the bus.
// - Power-control bit 4 removes common clock from bus; power-down counter still clocked.
// - Power-control bit 5 stops macrocell clocking only; bus and counter keep it.
// - Common clock feeds macrocells, logic bus term and the auto power-down counter.
// - Non-turbo: any transition on an unblocked strobe wakes the logic arrays.
// - Non-turbo: latch and sleep between transitions; fast inputs behave as turbo.
// - When configured, standby indicator pin outputs the battery switch-over state.
// - Power-control bit 3: zero keeps turbo on by default, one allows standby.
// - Counter counts idle ALE clock periods, indicates power-down at 15, ALE clears.
// - Both registers clear on power-up reset, unchanged by warm reset and power-down.
`timescale 1ns/1ns
module pld_input_blocking
    import pld_block_pkg::*;
(
    // Clock and resets
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       warm_rst,
    // Register port
    input  wire logic       reg_sel,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Pins from outside the clock domain
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       psen_n,
    input  wire logic       ale,
    input  wire logic       port_c_bit7_input,
    input  wire logic       common_clock_in,
    input  wire logic       battery_switched,
    // Configuration levels
    input  wire logic       clock_pin_assigned,
    input  wire logic       standby_ind_en,
    // Memory array strobes
    output logic            mem_rd_n,
    output logic            mem_wr_n,
    output logic            mem_psen_n,
    output logic            mem_ale,
    // Logic input bus
    output logic            pld_rd_n,
    output logic            pld_wr_n,
    output logic            pld_psen_n,
    output logic            pld_ale,
    output logic            pld_port_c7,
    output logic            pld_clk_term,
    output logic            power_down_indicator,
    // Output macrocell clock and array power state
    output logic            macrocell_clk_en,
    output logic            pld_standby,
    // Standby indicator pin
    output logic            standby_indicator_pin_out,
    output logic            standby_indicator_pin_oe
);

    typedef struct packed {
        logic [7:0]         pwr;
        logic [7:0]         blk;
        logic [N_LANES-1:0] s1;
        logic [N_LANES-1:0] s2;
        logic               ale_prev;
        logic               clk_prev;
        logic [3:0]         pd_cnt;
        logic               pd_flag;
        logic [4:0]         bus;
        logic               clk_term;
        logic               mc_en;
        logic [LATCH_W-1:0] idle_cnt;
        logic               standby;
        logic [3:0]         mem;
        logic [7:0]         rdata;
        logic               stby_out;
    } state_t;

    state_t q;
    state_t d;

    logic clk_src;
    logic clk_rise;
    logic ale_edge;
    logic bus_change;

    always_comb begin
        d = q;
        // Second stage alone reads the first
        d.s1 = {battery_switched, common_clock_in, port_c_bit7_input, ale, psen_n, wr_n, rd_n};
        d.s2 = q.s1;

        // Without the pin assigned there is no clock source at all
        clk_src  = q.s2[LN_CLK] & clock_pin_assigned;
        clk_rise = clk_src & ~q.clk_prev;
        ale_edge = q.s2[LN_ALE] ^ q.ale_prev;
        d.clk_prev = clk_src;
        d.ale_prev = q.s2[LN_ALE];

        // Registers change only by host write; warm reset and power-down leave them
        if (reg_wr) begin
            if (reg_sel == SEL_POWER_CTRL) begin
                d.pwr = reg_wdata;
            end else begin
                d.blk = reg_wdata;
            end
        end
        d.rdata = (reg_sel == SEL_POWER_CTRL) ? q.pwr : q.blk;

        // Memory arrays see every strobe whatever the block bits say
        d.mem = q.s2[LN_ALE:LN_RD];

        for (int i = 0; i < 4; i++) begin
            d.bus[i] = q.blk[IB_STROBE_LSB + i] ? BUS_IDLE[i] : q.s2[i];
        end
        d.bus[LN_PORTC7] = q.blk[IB_PORTC7] ? BUS_IDLE[LN_PORTC7] : q.s2[LN_PORTC7];

        d.clk_term = clk_src & ~q.pwr[PC_CLK_BUS_BLK];
        d.mc_en    = clk_rise & ~q.pwr[PC_CLK_MC_BLK];

        // Counter keeps its clock even when bus or macrocell paths are blocked
        if (ale_edge || !q.pwr[PC_AUTO_PD_EN] || warm_rst) begin
            d.pd_cnt  = 4'h0;
            d.pd_flag = 1'b0;
        end else if (clk_rise && !q.pd_flag) begin
            d.pd_cnt  = q.pd_cnt + 4'h1;
            d.pd_flag = (q.pd_cnt == IDLE_LIMIT - 4'h1);
        end

        // Any change on an unblocked input, including clock and power-down terms, wakes the arrays
        bus_change = (d.bus != q.bus) || (d.clk_term != q.clk_term) || (d.pd_flag != q.pd_flag);
        if (!q.pwr[PC_TURBO_OFF] || bus_change || warm_rst) begin
            d.idle_cnt = '0;
            d.standby  = 1'b0;
        end else if (q.idle_cnt != LATCH_W'(PLD_LATCH_CYC)) begin
            // Inputs faster than the latch time never reach standby, as in turbo
            d.idle_cnt = q.idle_cnt + LATCH_W'(1);
        end else begin
            d.standby = 1'b1;
        end

        d.stby_out = q.s2[LN_BAT];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q          <= '0;
            q.pwr      <= REG_RESET;
            q.blk      <= REG_RESET;
            q.s1       <= PIN_RESET;
            q.s2       <= PIN_RESET;
            q.bus      <= BUS_IDLE;
            q.mem      <= PIN_RESET[3:0];
        end else begin
            q <= d;
        end
    end

    assign reg_rdata                 = q.rdata;
    assign mem_rd_n                  = q.mem[LN_RD];
    assign mem_wr_n                  = q.mem[LN_WR];
    assign mem_psen_n                = q.mem[LN_PSEN];
    assign mem_ale                   = q.mem[LN_ALE];
    assign pld_rd_n                  = q.bus[LN_RD];
    assign pld_wr_n                  = q.bus[LN_WR];
    assign pld_psen_n                = q.bus[LN_PSEN];
    assign pld_ale                   = q.bus[LN_ALE];
    assign pld_port_c7               = q.bus[LN_PORTC7];
    assign pld_clk_term              = q.clk_term;
    assign power_down_indicator      = q.pd_flag;
    assign macrocell_clk_en          = q.mc_en;
    assign pld_standby               = q.standby;
    assign standby_indicator_pin_out = q.stby_out;
    assign standby_indicator_pin_oe  = standby_ind_en;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Strobe gating: a set block bit parks the bus input at its idle level
    a_strobe_gate: assert property (q.blk[IB_STROBE_LSB] |=> pld_rd_n)
        else $error("blocked read strobe reached the logic bus");

    a_wr_gate: assert property (q.blk[IB_STROBE_LSB + 1] |=> pld_wr_n)
        else $error("blocked write strobe reached the logic bus");

    a_psen_gate: assert property (q.blk[IB_STROBE_LSB + 2] |=> pld_psen_n)
        else $error("blocked program strobe reached the logic bus");

    a_ale_gate: assert property (q.blk[IB_STROBE_LSB + 3] |=> !pld_ale)
        else $error("blocked latch strobe reached the logic bus");

    a_rd_pass: assert property (!q.blk[IB_STROBE_LSB] |=> pld_rd_n == $past(q.s2[LN_RD]))
        else $error("open read strobe not passed to the logic bus");

    a_wr_pass: assert property (!q.blk[IB_STROBE_LSB + 1] |=> pld_wr_n == $past(q.s2[LN_WR]))
        else $error("open write strobe not passed to the logic bus");

    a_psen_pass: assert property (!q.blk[IB_STROBE_LSB + 2] |=> pld_psen_n == $past(q.s2[LN_PSEN]))
        else $error("open program strobe not passed to the logic bus");

    a_ale_pass: assert property (!q.blk[IB_STROBE_LSB + 3] |=> pld_ale == $past(q.s2[LN_ALE]))
        else $error("open latch strobe not passed to the logic bus");

    a_portc_gate: assert property (q.blk[IB_PORTC7] |=> !pld_port_c7)
        else $error("blocked port C bit 7 reached the logic bus");

    a_portc_pass: assert property (!q.blk[IB_PORTC7] |=> pld_port_c7 == $past(q.s2[LN_PORTC7]))
        else $error("open port C bit 7 not passed to the logic bus");

    // Memory arrays see the raw strobes whatever the block bits hold
    a_mem_pass: assert property (##1 mem_wr_n == $past(q.s2[LN_WR]))
        else $error("memory write strobe not passed through");

    a_mem_rd: assert property (1'b1 |=> mem_rd_n == $past(q.s2[LN_RD]))
        else $error("memory read strobe not passed through");

    a_mem_psen: assert property (1'b1 |=> mem_psen_n == $past(q.s2[LN_PSEN]))
        else $error("memory program strobe not passed through");

    a_mem_ale: assert property (1'b1 |=> mem_ale == $past(q.s2[LN_ALE]))
        else $error("memory latch strobe not passed through");

    // Common clock distribution to bus term and macrocells
    a_clk_bus_gate: assert property (q.pwr[PC_CLK_BUS_BLK] |=> !pld_clk_term)
        else $error("blocked clock reached the logic bus");

    a_clk_bus_pass: assert property (!q.pwr[PC_CLK_BUS_BLK] |=> pld_clk_term == $past(clk_src))
        else $error("open clock not passed to the logic bus");

    a_mc_gate: assert property (q.pwr[PC_CLK_MC_BLK] |=> !macrocell_clk_en)
        else $error("blocked clock enabled the macrocells");

    a_mc_clock: assert property (!q.pwr[PC_CLK_MC_BLK] && clk_rise |=> macrocell_clk_en)
        else $error("clock edge missed by the macrocells");

    a_mc_no_edge: assert property (!clk_rise |=> !macrocell_clk_en)
        else $error("macrocells enabled without a clock edge");

    a_mc_pulse: assert property (macrocell_clk_en |=> !macrocell_clk_en)
        else $error("macrocell enable longer than one cycle");

    a_mc_keeps_bus: assert property (q.pwr[PC_CLK_MC_BLK] && !q.pwr[PC_CLK_BUS_BLK]
                                     |=> pld_clk_term == $past(clk_src))
        else $error("macrocell blocking removed the clock bus term");

    a_no_source: assert property (!clock_pin_assigned |=> !pld_clk_term && !macrocell_clk_en)
        else $error("clock terms present without a clock pin");

    // Power-down counter keeps its clock whatever the other blocking bits say
    a_cnt_bus_blk: assert property (q.pwr[PC_CLK_BUS_BLK] && q.pwr[PC_AUTO_PD_EN] && clk_rise && !ale_edge
                                    && !warm_rst && !q.pd_flag |=> q.pd_cnt == $past(q.pd_cnt) + 4'h1)
        else $error("bus clock blocking stopped the idle counter");

    a_cnt_mc_blk: assert property (q.pwr[PC_CLK_MC_BLK] && q.pwr[PC_AUTO_PD_EN] && clk_rise && !ale_edge
                                   && !warm_rst && !q.pd_flag |=> q.pd_cnt == $past(q.pd_cnt) + 4'h1)
        else $error("macrocell clock blocking stopped the idle counter");

    a_pd_clear: assert property (ale_edge |=> q.pd_cnt == 4'h0 && !power_down_indicator)
        else $error("ALE transition did not clear the counter");

    a_pd_count: assert property ($rose(power_down_indicator) |-> q.pd_cnt == IDLE_LIMIT)
        else $error("power-down indicated at wrong count");

    a_pd_clocked: assert property ($rose(power_down_indicator) |-> $past(clk_rise))
        else $error("power-down indicated without a clock edge");

    a_pd_early: assert property (!power_down_indicator && q.pd_cnt < IDLE_LIMIT - 4'h1
                                 |=> !power_down_indicator)
        else $error("power-down indicated too early");

    a_pd_hold: assert property (power_down_indicator && !ale_edge && q.pwr[PC_AUTO_PD_EN] && !warm_rst
                                |=> power_down_indicator)
        else $error("power-down indicator dropped while idle");

    a_pd_off: assert property (!q.pwr[PC_AUTO_PD_EN] |=> !power_down_indicator && q.pd_cnt == 4'h0)
        else $error("disabled counter left running");

    a_warm_clear: assert property (warm_rst |=> !power_down_indicator && !pld_standby)
        else $error("warm reset left power-down or standby set");

    // Array standby in turbo and non-turbo mode, and the standby indicator pin
    a_turbo_awake: assert property (!q.pwr[PC_TURBO_OFF] |=> !pld_standby)
        else $error("standby entered in turbo mode");

    a_turbo_idle: assert property (!q.pwr[PC_TURBO_OFF] |=> q.idle_cnt == '0)
        else $error("latch timer ran in turbo mode");

    a_wake_edge: assert property (bus_change |=> !pld_standby [*2])
        else $error("input transition did not wake the arrays");

    a_stby_settle: assert property (pld_standby && !bus_change && q.pwr[PC_TURBO_OFF] && !warm_rst
                                    |=> pld_standby)
        else $error("arrays left standby with quiet inputs");

    a_stby_quiet: assert property ($rose(pld_standby) |-> q.idle_cnt == LATCH_W'(PLD_LATCH_CYC))
        else $error("standby entered before the latch time");

    a_stby_pin: assert property (1'b1 |=> standby_indicator_pin_out == $past(q.s2[LN_BAT]))
        else $error("standby pin does not follow the battery state");

    // Control registers
    a_reg_hold: assert property (warm_rst && !reg_wr |=> $stable(q.pwr) && $stable(q.blk))
        else $error("warm reset changed a control register");

    a_reg_idle: assert property (!reg_wr |=> $stable(q.pwr) && $stable(q.blk))
        else $error("control register changed without a write");

    a_pwr_write: assert property (reg_wr && reg_sel == SEL_POWER_CTRL |=> q.pwr == $past(reg_wdata))
        else $error("power control write lost");

    a_blk_write: assert property (reg_wr && reg_sel == SEL_INPUT_BLK |=> q.blk == $past(reg_wdata))
        else $error("input block write lost");

endmodule

//--- testbench/host_strobes.sv
// Host bus strobe model: random strobe traffic or a joint flip of rd_n and ale
`timescale 1ns/1ns
module host_strobes (
    // Clock and activity controls
    input  wire logic clk,
    input  wire logic act,
    input  wire logic flip,
    // Bus control strobes
    output logic      rd_n,
    output logic      wr_n,
    output logic      psen_n,
    output logic      ale
);
    initial {rd_n, wr_n, psen_n, ale} = 4'hE;
    // Strobes move only just after an edge and hold otherwise
    always @(posedge clk) begin
        if (act) begin
            {rd_n, wr_n, psen_n, ale} <= 4'($urandom);
        end else if (flip) begin
            {rd_n, ale} <= {~rd_n, ~ale};
        end
    end
endmodule

//--- testbench/test_pld_input_blocking.sv
// Self-checking bench for the logic array input gating block
`timescale 1ns/1ns
module test_pld_input_blocking;
    import pld_block_pkg::*;
    logic       clk = 0, rst_b = 0, warm_rst = 0, reg_sel = 0, reg_wr = 0;
    logic       act = 0, flip = 0, pc_bit7 = 0, cki = 0, bat = 0;
    logic       cka = 1, sie = 1;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, blk = 8'h00, pwr = 8'h00, v;
    logic [6:0] h1, h2, h3, h4;
    logic       rd_n, wr_n, psen_n, ale, mem_rd_n, mem_wr_n, mem_psen_n, mem_ale;
    logic       pld_rd_n, pld_wr_n, pld_psen_n, pld_ale, pld_port_c7, pld_clk_term;
    logic       power_down_indicator, macrocell_clk_en, pld_standby;
    logic       standby_indicator_pin_out, standby_indicator_pin_oe;
    int         failures = 0, n_checks = 0, quiet = 8, cyc = 0;

    always #10 clk = ~clk;

    host_strobes u_host_strobes (.clk, .act, .flip, .rd_n, .wr_n, .psen_n, .ale);

    pld_input_blocking u_pld_input_blocking (
        .clk, .rst_b, .warm_rst, .reg_sel, .reg_wr, .reg_wdata, .reg_rdata,
        .rd_n, .wr_n, .psen_n, .ale, .port_c_bit7_input(pc_bit7), .common_clock_in(cki),
        .battery_switched(bat), .clock_pin_assigned(cka), .standby_ind_en(sie),
        .mem_rd_n, .mem_wr_n, .mem_psen_n, .mem_ale, .pld_rd_n, .pld_wr_n, .pld_psen_n,
        .pld_ale, .pld_port_c7, .pld_clk_term, .power_down_indicator, .macrocell_clk_en,
        .pld_standby, .standby_indicator_pin_out, .standby_indicator_pin_oe);

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude();
        $display("Counts: %0d checks, %0d failures", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic wreg(logic s, logic [7:0] d);
        @(posedge clk);
        reg_sel <= s;
        reg_wr <= 1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
        quiet = 4;
        if (s == SEL_INPUT_BLK) blk = d;
        else pwr = d;
    endtask

    task automatic rreg(logic s, logic [7:0] e);
        @(posedge clk);
        reg_sel <= s;
        @(posedge clk);
        @(negedge clk);
        chk("reg_rdata", e, reg_rdata);
    endtask

    task automatic wait_chk(int n, string nm, logic e, logic g_sel);
        repeat (n) @(posedge clk);
        @(negedge clk);
        chk(nm, 8'(e), 8'(g_sel ? pld_standby : power_down_indicator));
    endtask

    // Reference model: pins seen three edges back, gated by the model registers
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            conclude();
        end
        {h4, h3, h2, h1} <= {h3, h2, h1, bat, cki, pc_bit7, ale, psen_n, wr_n, rd_n};
        if (rst_b && quiet > 0) quiet--;
        if (rst_b && quiet == 0) begin
            chk("mem strobes", 8'(h3[3:0]), 8'({mem_ale, mem_psen_n, mem_wr_n, mem_rd_n}));
            chk("pld inputs", 8'((h3[4:0] & ~blk[6:2]) | (BUS_IDLE & blk[6:2])),
                8'({pld_port_c7, pld_ale, pld_psen_n, pld_wr_n, pld_rd_n}));
            chk("pld_clk_term", 8'(h3[LN_CLK] & cka & ~pwr[PC_CLK_BUS_BLK]), 8'(pld_clk_term));
            chk("macrocell_clk_en", 8'(h3[LN_CLK] & ~h4[LN_CLK] & cka & ~pwr[PC_CLK_MC_BLK]),
                8'(macrocell_clk_en));
            chk("standby pin", 8'({sie, h3[LN_BAT]}),
                8'({standby_indicator_pin_oe, standby_indicator_pin_out}));
        end
    end

    initial begin
        void'($urandom(32'hB39E521E));
        repeat (8) @(posedge clk);
        rst_b <= 1;
        rreg(SEL_POWER_CTRL, REG_RESET);
        rreg(SEL_INPUT_BLK, REG_RESET);
        $display("Test reset values done");
        act <= 1;
        // Blocking changes under strobe traffic, unblock and reblock included
        repeat (20) begin
            v = 8'($urandom);
            wreg(SEL_INPUT_BLK, v);
            rreg(SEL_INPUT_BLK, v);
            v = 8'($urandom);
            wreg(SEL_POWER_CTRL, v);
            repeat (12) begin
                cki <= ~cki;
                pc_bit7 <= 1'($urandom);
                bat <= 1'($urandom);
                @(posedge clk);
            end
        end
        $display("Test random blocking done");
        // Clock pin unassigned and indicator pin undriven: no clock terms reach the arrays
        cka <= 0;
        sie <= 0;
        quiet = 4;
        repeat (12) begin
            cki <= ~cki;
            bat <= 1'($urandom);
            @(posedge clk);
        end
        cka <= 1;
        sie <= 1;
        quiet = 4;
        $display("Test clock source done");
        act <= 0;
        wreg(SEL_INPUT_BLK, 8'h00);
        wreg(SEL_POWER_CTRL, 8'h08);
        wait_chk(16, "pld_standby", 1'b1, 1'b1);
        @(posedge clk);
        flip <= 1;
        @(posedge clk);
        flip <= 0;
        wait_chk(7, "pld_standby", 1'b0, 1'b1);
        wreg(SEL_POWER_CTRL, 8'h00);
        wait_chk(16, "pld_standby", 1'b0, 1'b1);
        $display("Test standby done");
        wreg(SEL_POWER_CTRL, 8'h02);
        warm_rst <= 1;
        @(posedge clk);
        warm_rst <= 0;
        repeat (14) begin
            cki <= 1;
            repeat (2) @(posedge clk);
            cki <= 0;
            repeat (2) @(posedge clk);
        end
        wait_chk(4, "power_down_indicator", 1'b0, 1'b0);
        @(posedge clk);
        cki <= 1;
        wait_chk(6, "power_down_indicator", 1'b1, 1'b0);
        @(posedge clk);
        flip <= 1;
        @(posedge clk);
        flip <= 0;
        wait_chk(8, "power_down_indicator", 1'b0, 1'b0);
        rreg(SEL_POWER_CTRL, 8'h02);
        $display("Test power-down counter done");
        // Second power-up reset in mid-run clears both registers again
        @(posedge clk);
        rst_b <= 0;
        blk = 8'h00;
        pwr = 8'h00;
        quiet = 8;
        repeat (3) @(posedge clk);
        rst_b <= 1;
        rreg(SEL_POWER_CTRL, REG_RESET);
        rreg(SEL_INPUT_BLK, REG_RESET);
        $display("Test second reset done");
        conclude();
    end
endmodule
